// File: verilog/jtb_tap.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - The bypass code 1111 puts a one-bit bypass register between serial input and output.
// - In bypass, data passes through on test clock edges while user logic keeps running.
// - A full instruction scan with the input held high loads all ones, which decode as bypass.
// - The identification code 0001 puts the identification register on the serial path.
// - Instruction and data bits are sampled from the serial input on rising test clock edges.
// - The serial output is updated on falling test clock edges while shifting.
// - The serial output floats whenever nothing is being shifted out.
// - Only four port pins exist: test clock, mode select, data in and data out, no test reset.
// - The power-up reset resets the test logic in place of a test reset pin.
// - An unconfigured device has its four port pins working as the test port.
// - With the port enabled, the macrocells behind the four pins stay usable as buried logic.
// - Once a loaded configuration disables the port, the four pins act as general I/O.
module jtb_tap (
   // System clock and power-up reset
   input  wire logic       CLK,
   input  wire logic       RESETN,
   // Test port pins
   input  wire logic       TCK,
   input  wire logic       TMS,
   input  wire logic       TDI,
   input  wire logic       TDO_I,
   output var  logic       TDO_O,
   output var  logic       TDO_OE,
   // Configuration load
   input  wire logic       CFG_LOAD,
   input  wire logic       CFG_TAP_DIS,
   output var  logic       TAP_ENABLED,
   // User macrocells behind the four port pins
   input  wire logic [3:0] USER_IO_O,
   input  wire logic [3:0] USER_IO_OE,
   output var  logic [3:0] GPIO_O,
   output var  logic [3:0] GPIO_OE,
   output var  logic [3:0] GPIO_I,
   output var  logic [3:0] BURIED_Q
);

   // ****************************************************************
   // Port enable, system clock side
   // ****************************************************************
   logic tap_en_q;

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         tap_en_q <= jtb_pkg::TAP_EN_RESET;
      end else if (CFG_LOAD && CFG_TAP_DIS) begin
         tap_en_q <= 1'h0;
      end
   end

   assign TAP_ENABLED = tap_en_q;

   // ****************************************************************
   // User pins and buried macrocells
   // ****************************************************************
   // buried feedback always live
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         BURIED_Q <= jtb_pkg::PIN_RESET;
      end else begin
         BURIED_Q <= USER_IO_O;
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         GPIO_O  <= jtb_pkg::PIN_RESET;
         GPIO_OE <= jtb_pkg::PIN_RESET;
      end else begin
         GPIO_O  <= USER_IO_O;
         GPIO_OE <= tap_en_q ? jtb_pkg::PIN_RESET : USER_IO_OE;
      end
   end

   // Pin levels come from outside, so they pass a synchroniser before use.
   jtb_sync #(
      .W   (jtb_pkg::PIN_N),
      .RST (jtb_pkg::PIN_RESET)
   ) u_pin_sync (
      .clk   (CLK),
      .rst_n (RESETN),
      .d     ({TDO_I, TDI, TMS, TCK}),
      .q     (GPIO_I)
   );

   // ****************************************************************
   // Crossing into the test clock domain
   // ****************************************************************
   logic trst_n;
   logic tap_en_tck;

   // power-up reset as test reset
   // Assertion is immediate, release waits for two test clock edges.
   jtb_sync #(
      .W   (1),
      .RST (1'h0)
   ) u_rst_sync (
      .clk   (TCK),
      .rst_n (RESETN),
      .d     (1'h1),
      .q     (trst_n)
   );

   jtb_sync #(
      .W   (1),
      .RST (jtb_pkg::TAP_EN_RESET)
   ) u_en_sync (
      .clk   (TCK),
      .rst_n (trst_n),
      .d     (tap_en_q),
      .q     (tap_en_tck)
   );

   // ****************************************************************
   // Port controller
   // ****************************************************************
   jtb_tap_if tap ();

   // four pins only
   // TMS is synchronous to TCK by contract, so it needs no synchroniser.
   assign tap.tms    = TMS;
   assign tap.tap_en = tap_en_tck;
   assign tap.rst_n  = trst_n;

   jtb_tap_fsm u_fsm (
      .tck (TCK),
      .tap (tap.ctl)
   );

   jtb_pkg::jtb_state_t st;
   assign st = tap.state;

   // ****************************************************************
   // Instruction register
   // ****************************************************************
   logic [jtb_pkg::IR_W-1:0] ir_sr_q;
   logic [jtb_pkg::IR_W-1:0] ir_q;
   logic                     sel_bypass;

   always_ff @(posedge TCK or negedge trst_n) begin
      if (!trst_n) begin
         ir_sr_q <= jtb_pkg::IR_CAPTURE;
      end else if (st == jtb_pkg::ST_CAP_IR) begin
         ir_sr_q <= jtb_pkg::IR_CAPTURE;
      end else if (st == jtb_pkg::ST_SH_IR) begin
         ir_sr_q <= {TDI, ir_sr_q[jtb_pkg::IR_W-1:1]};
      end
   end

   always_ff @(posedge TCK or negedge trst_n) begin
      if (!trst_n) begin
         ir_q <= jtb_pkg::IR_RESET;
      end else if (st == jtb_pkg::ST_TLR) begin
         ir_q <= jtb_pkg::IR_RESET;
      end else if (st == jtb_pkg::ST_UP_IR) begin
         ir_q <= ir_sr_q;
      end
   end

   assign sel_bypass = jtb_pkg::jtb_is_bypass(ir_q);

   // ****************************************************************
   // Data registers
   // ****************************************************************
   logic                     bypass_q;
   logic [jtb_pkg::ID_W-1:0] id_sr_q;

   always_ff @(posedge TCK or negedge trst_n) begin
      if (!trst_n) begin
         bypass_q <= 1'h0;
      end else if (sel_bypass && st == jtb_pkg::ST_CAP_DR) begin
         bypass_q <= 1'h0;
      end else if (sel_bypass && st == jtb_pkg::ST_SH_DR) begin
         bypass_q <= TDI;
      end
   end

   always_ff @(posedge TCK or negedge trst_n) begin
      if (!trst_n) begin
         id_sr_q <= jtb_pkg::ID_DEFAULT;
      end else if (!sel_bypass && st == jtb_pkg::ST_CAP_DR) begin
         id_sr_q <= jtb_pkg::ID_DEFAULT;
      end else if (!sel_bypass && st == jtb_pkg::ST_SH_DR) begin
         id_sr_q <= {TDI, id_sr_q[jtb_pkg::ID_W-1:1]};
      end
   end

   // ****************************************************************
   // Serial output
   // ****************************************************************
   logic shifting;
   logic tdo_d;

   assign shifting = (st == jtb_pkg::ST_SH_IR) || (st == jtb_pkg::ST_SH_DR);

   always_comb begin
      if (st == jtb_pkg::ST_SH_IR) begin
         tdo_d = ir_sr_q[0];
      end else if (sel_bypass) begin
         tdo_d = bypass_q;
      end else begin
         tdo_d = id_sr_q[0];
      end
   end

   // launch on falling edge
   // Half a period of margin keeps the next device's rising-edge setup safe.
   always_ff @(negedge TCK or negedge trst_n) begin
      if (!trst_n) begin
         TDO_O <= 1'h0;
      end else if (shifting) begin
         TDO_O <= tdo_d;
      end
   end

   always_ff @(negedge TCK or negedge trst_n) begin
      if (!trst_n) begin
         TDO_OE <= 1'h0;
      end else begin
         TDO_OE <= shifting && tap_en_tck;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   // bypass captures zero
   a_bypass_capture: assert property (
      @(posedge TCK) disable iff (!trst_n)
      (sel_bypass && st == jtb_pkg::ST_CAP_DR) |=> (bypass_q == 1'h0))
      else $error("Bypass stage did not capture zero.");

   a_bypass_pass: assert property (
      @(posedge TCK) disable iff (!trst_n)
      (sel_bypass && st == jtb_pkg::ST_SH_DR) |=> (bypass_q == $past(TDI)))
      else $error("Bypass stage did not take the input bit.");

   a_ones_bypass: assert property (
      @(posedge TCK) disable iff (!trst_n)
      ((st == jtb_pkg::ST_SH_IR) && TDI) [*4] ##1 (st == jtb_pkg::ST_EX1_IR)
      ##1 (st == jtb_pkg::ST_UP_IR) |=> sel_bypass)
      else $error("All-ones instruction scan did not select bypass.");

   a_id_capture: assert property (
      @(posedge TCK) disable iff (!trst_n)
      (!sel_bypass && st == jtb_pkg::ST_CAP_DR) |=> (id_sr_q == jtb_pkg::ID_DEFAULT))
      else $error("Identification register did not load its code.");

   a_ir_sample: assert property (
      @(posedge TCK) disable iff (!trst_n)
      (st == jtb_pkg::ST_SH_IR) |=> (ir_sr_q[jtb_pkg::IR_W-1] == $past(TDI)))
      else $error("Instruction shift missed the input bit.");

   a_tdo_launch: assert property (
      @(negedge TCK) disable iff (!trst_n)
      (!sel_bypass && st == jtb_pkg::ST_SH_DR) |=> (TDO_O == $past(id_sr_q[0])))
      else $error("Serial output did not launch the identification bit.");

   a_tdo_float: assert property (
      @(negedge TCK) disable iff (!trst_n)
      !shifting |=> !TDO_OE)
      else $error("Serial output driven while not shifting.");

   a_reset_ir: assert property (
      @(posedge TCK) disable iff (!trst_n)
      (st == jtb_pkg::ST_TLR) |=> (ir_q == jtb_pkg::IR_RESET))
      else $error("Instruction register missed its default code.");

   a_gpio_mode: assert property (
      @(posedge CLK) disable iff (!RESETN)
      !tap_en_q |=> (!tap_en_q && GPIO_OE == $past(USER_IO_OE)))
      else $error("Pins not handed over as general I/O.");

   a_buried_fb: assert property (
      @(posedge CLK) disable iff (!RESETN)
      tap_en_q |=> (BURIED_Q == $past(USER_IO_O) && GPIO_OE == 4'h0))
      else $error("Buried macrocell path lost while port enabled.");

   a_tdo_drive: assert property (
      @(negedge TCK) disable iff (!trst_n)
      (shifting && tap_en_tck) |=> TDO_OE)
      else $error("Serial output not driven while shifting.");

   a_ir_launch: assert property (
      @(negedge TCK) disable iff (!trst_n)
      (st == jtb_pkg::ST_SH_IR) |=> (TDO_O == $past(ir_sr_q[0])))
      else $error("Serial output did not launch the instruction bit.");

   a_bypass_out: assert property (
      @(negedge TCK) disable iff (!trst_n)
      (sel_bypass && st == jtb_pkg::ST_SH_DR) |=> (TDO_O == $past(bypass_q)))
      else $error("Serial output did not launch the bypass bit.");

   a_port_refused: assert property (
      @(posedge TCK) disable iff (!trst_n)
      !tap_en_tck |=> (st == jtb_pkg::ST_TLR))
      else $error("Controller left reset while the port is disabled.");

   a_id_shift: assert property (
      @(posedge TCK) disable iff (!trst_n)
      (!sel_bypass && st == jtb_pkg::ST_SH_DR) |=> (id_sr_q[jtb_pkg::ID_W-1] == $past(TDI)))
      else $error("Identification shift missed the input bit.");

   a_ir_update: assert property (
      @(posedge TCK) disable iff (!trst_n)
      (st == jtb_pkg::ST_UP_IR) |=> (ir_q == $past(ir_sr_q)))
      else $error("Instruction register did not take the shifted code.");

   a_en_sticky: assert property (
      @(posedge CLK) disable iff (!RESETN)
      !tap_en_q |=> !TAP_ENABLED)
      else $error("Port enable came back without a reset.");

endmodule : jtb_tap
`default_nettype wire

// File: verilog/jtb_pkg.sv
`default_nettype none
package jtb_pkg;

   // ****************************************************************
   // Instruction register
   // ****************************************************************
   localparam int         IR_W       = 4;
   localparam logic [3:0] INS_BYPASS = 4'hF;
   localparam logic [3:0] INS_IDCODE = 4'h1;
   localparam logic [3:0] IR_RESET   = INS_IDCODE;
   // Low two bits fixed at 01 so a broken chain is easy to spot.
   localparam logic [3:0] IR_CAPTURE = 4'h1;

   // ****************************************************************
   // Identification register
   // ****************************************************************
   localparam int          ID_W       = 32;
   // Arbitrary neutral value; bit 0 must stay set.
   localparam logic [31:0] ID_DEFAULT = 32'h0A5C_3001;

   // ****************************************************************
   // Reset values and pin map
   // ****************************************************************
   localparam logic       TAP_EN_RESET = 1'h1;
   localparam int         PIN_N        = 4;
   localparam logic [3:0] PIN_RESET    = 4'h0;

   // ****************************************************************
   // Port controller states
   // ****************************************************************
   typedef enum logic [15:0] {
      ST_TLR    = 16'h0001,
      ST_RTI    = 16'h0002,
      ST_SEL_DR = 16'h0004,
      ST_CAP_DR = 16'h0008,
      ST_SH_DR  = 16'h0010,
      ST_EX1_DR = 16'h0020,
      ST_PA_DR  = 16'h0040,
      ST_EX2_DR = 16'h0080,
      ST_UP_DR  = 16'h0100,
      ST_SEL_IR = 16'h0200,
      ST_CAP_IR = 16'h0400,
      ST_SH_IR  = 16'h0800,
      ST_EX1_IR = 16'h1000,
      ST_PA_IR  = 16'h2000,
      ST_EX2_IR = 16'h4000,
      ST_UP_IR  = 16'h8000
   } jtb_state_t;

   // Every code other than the identification code selects bypass.
   function automatic logic jtb_is_bypass(input logic [3:0] ir);
      return (ir != INS_IDCODE);
   endfunction : jtb_is_bypass

endpackage : jtb_pkg
`default_nettype wire

// File: verilog/jtb_tap_if.sv
`timescale 1ns/1ps
`default_nettype none
interface jtb_tap_if;
   logic               tms;
   logic               tap_en;
   logic               rst_n;
   jtb_pkg::jtb_state_t state;

   modport ctl (input tms, input tap_en, input rst_n, output state);
   modport dp  (output tms, output tap_en, output rst_n, input state);
endinterface : jtb_tap_if
`default_nettype wire

// File: verilog/jtb_sync.sv
`timescale 1ns/1ps
`default_nettype none
module jtb_sync #(
   parameter int         W   = 1,
   parameter logic [W-1:0] RST = '0
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Data
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= RST;
         q      <= RST;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : jtb_sync
`default_nettype wire

// File: verilog/jtb_tap_fsm.sv
`timescale 1ns/1ps
`default_nettype none
module jtb_tap_fsm (
   // Link clock
   input  wire logic tck,
   // Controller side
   jtb_tap_if.ctl    tap
);
   jtb_pkg::jtb_state_t state_q;
   jtb_pkg::jtb_state_t state_d;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         jtb_pkg::ST_TLR:    state_d = tap.tms ? jtb_pkg::ST_TLR    : jtb_pkg::ST_RTI;
         jtb_pkg::ST_RTI:    state_d = tap.tms ? jtb_pkg::ST_SEL_DR : jtb_pkg::ST_RTI;
         jtb_pkg::ST_SEL_DR: state_d = tap.tms ? jtb_pkg::ST_SEL_IR : jtb_pkg::ST_CAP_DR;
         jtb_pkg::ST_CAP_DR: state_d = tap.tms ? jtb_pkg::ST_EX1_DR : jtb_pkg::ST_SH_DR;
         jtb_pkg::ST_SH_DR:  state_d = tap.tms ? jtb_pkg::ST_EX1_DR : jtb_pkg::ST_SH_DR;
         jtb_pkg::ST_EX1_DR: state_d = tap.tms ? jtb_pkg::ST_UP_DR  : jtb_pkg::ST_PA_DR;
         jtb_pkg::ST_PA_DR:  state_d = tap.tms ? jtb_pkg::ST_EX2_DR : jtb_pkg::ST_PA_DR;
         jtb_pkg::ST_EX2_DR: state_d = tap.tms ? jtb_pkg::ST_UP_DR  : jtb_pkg::ST_SH_DR;
         jtb_pkg::ST_UP_DR:  state_d = tap.tms ? jtb_pkg::ST_SEL_DR : jtb_pkg::ST_RTI;
         jtb_pkg::ST_SEL_IR: state_d = tap.tms ? jtb_pkg::ST_TLR    : jtb_pkg::ST_CAP_IR;
         jtb_pkg::ST_CAP_IR: state_d = tap.tms ? jtb_pkg::ST_EX1_IR : jtb_pkg::ST_SH_IR;
         jtb_pkg::ST_SH_IR:  state_d = tap.tms ? jtb_pkg::ST_EX1_IR : jtb_pkg::ST_SH_IR;
         jtb_pkg::ST_EX1_IR: state_d = tap.tms ? jtb_pkg::ST_UP_IR  : jtb_pkg::ST_PA_IR;
         jtb_pkg::ST_PA_IR:  state_d = tap.tms ? jtb_pkg::ST_EX2_IR : jtb_pkg::ST_PA_IR;
         jtb_pkg::ST_EX2_IR: state_d = tap.tms ? jtb_pkg::ST_UP_IR  : jtb_pkg::ST_SH_IR;
         jtb_pkg::ST_UP_IR:  state_d = tap.tms ? jtb_pkg::ST_SEL_DR : jtb_pkg::ST_RTI;
         default:            state_d = jtb_pkg::ST_TLR;
      endcase
   end

   always_ff @(posedge tck or negedge tap.rst_n) begin
      if (!tap.rst_n) begin
         state_q <= jtb_pkg::ST_TLR;
      end else if (!tap.tap_en) begin
         state_q <= jtb_pkg::ST_TLR;
      end else begin
         state_q <= state_d;
      end
   end

   assign tap.state = state_q;

   a_tms_reset_walk: assert property (
      @(posedge tck) disable iff (!tap.rst_n)
      tap.tms [*5] |=> (state_q == jtb_pkg::ST_TLR))
      else $error("Five TMS ones did not reach test-logic-reset.");
endmodule : jtb_tap_fsm
`default_nettype wire

// File: testbench/jtb_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module jtb_ctl_model (
   // Test port pins driven by the controller
   output var  logic tck,
   output var  logic tms,
   output var  logic tdi,
   // Resolved data-out pad
   input  wire logic tdo
);
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end

   // ****************************************************************
   // One test clock period
   // ****************************************************************
   // The clock rests low between calls, so it stands still outside frames.
   task automatic bit_x(input logic tms_v, input logic tdi_v, output logic pre, output logic post);
      tms = tms_v;
      tdi = tdi_v;
      #14;
      // The output is read late in the low phase.
      pre = tdo;
      // Inputs are held across the rising edge.
      tck = 1'b1;
      #2;
      post = tdo;
      #14;
      tck = 1'b0;
      #2;
   endtask : bit_x
endmodule : jtb_ctl_model
`default_nettype wire

// File: testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic       clk;
   logic       rst_n;
   logic       tck;
   logic       tms;
   logic       tdi;
   logic       tdo_o;
   logic       tdo_oe;
   logic       cfg_load;
   logic       cfg_tap_dis;
   logic       tap_enabled;
   logic [3:0] user_o;
   logic [3:0] user_oe;
   logic [3:0] gpio_o;
   logic [3:0] gpio_oe;
   logic [3:0] gpio_i;
   logic [3:0] buried_q;
   logic [39:0] d;
   int         err_total;
   int         checked;
   int         cyc = 0;
   // The pad has a pull-up when neither the port nor the user drives it.
   wire        tdo_pad = tdo_oe ? tdo_o : (gpio_oe[3] ? gpio_o[3] : 1'b1);

   jtb_tap u_jtb_tap (
      .CLK(clk), .RESETN(rst_n), .TCK(tck), .TMS(tms), .TDI(tdi), .TDO_I(tdo_pad),
      .TDO_O(tdo_o), .TDO_OE(tdo_oe), .CFG_LOAD(cfg_load), .CFG_TAP_DIS(cfg_tap_dis),
      .TAP_ENABLED(tap_enabled), .USER_IO_O(user_o), .USER_IO_OE(user_oe),
      .GPIO_O(gpio_o), .GPIO_OE(gpio_oe), .GPIO_I(gpio_i), .BURIED_Q(buried_q)
   );

   jtb_ctl_model u_jtb_ctl_model (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_pad));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ****************************************************************
   // Checking and closing
   // ****************************************************************
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic close_out();
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : close_out

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         close_out();
      end
   end

   // ****************************************************************
   // Scan helpers
   // ****************************************************************
   task automatic tap_bit(input logic m, input logic v);
      logic p;
      logic q;
      u_jtb_ctl_model.bit_x(m, v, p, q);
   endtask : tap_bit

   // Runs one scan from Run-Test/Idle back to Run-Test/Idle, LSB first.
   task automatic scan(input logic is_ir, input int n, input logic [39:0] din,
                       output logic [39:0] dout);
      logic p;
      logic q;
      dout = '0;
      tap_bit(1'b1, 1'b0);
      if (is_ir) begin
         tap_bit(1'b1, 1'b0);
      end
      tap_bit(1'b0, 1'b0);
      tap_bit(1'b0, 1'b0);
      chk(40'(tdo_oe), 40'h1);
      for (int i = 0; i < n; i++) begin
         u_jtb_ctl_model.bit_x(i == n - 1, din[i], p, q);
         dout[i] = p;
         chk(40'(q), 40'(p));
         chk(40'(tdo_oe), 40'(i < n - 1));
      end
      tap_bit(1'b1, 1'b0);
      tap_bit(1'b0, 1'b0);
      chk(40'(tdo_oe), 40'h0);
   endtask : scan

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic do_reset();
      @(posedge clk) rst_n <= 1'b0;
      repeat (16) @(posedge clk);
      #1;
      chk(40'(tap_enabled), 40'h1);
      chk(40'(tdo_oe), 40'h0);
      @(posedge clk) rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      repeat (5) tap_bit(1'b1, 1'b1);
      tap_bit(1'b0, 1'b0);
   endtask : do_reset

   // The 33rd bit out is the first bit in, which pins the length at 32.
   task automatic t_idcode();
      scan(1'b0, 33, 40'h1, d);
      chk(d, {7'h0, 1'b1, jtb_pkg::ID_DEFAULT});
   endtask : t_idcode

   task automatic t_bypass();
      scan(1'b1, 4, 40'(jtb_pkg::INS_BYPASS), d);
      chk(d, 40'(jtb_pkg::IR_CAPTURE));
      @(posedge clk) user_o <= 4'h3;
      scan(1'b0, 8, 40'hB5, d);
      chk(d, 40'h6A);
      chk(40'(buried_q), 40'h3);
   endtask : t_bypass

   task automatic t_ir_idcode();
      scan(1'b1, 4, 40'(jtb_pkg::INS_IDCODE), d);
      chk(d, 40'(jtb_pkg::IR_CAPTURE));
      t_idcode();
   endtask : t_ir_idcode

   task automatic t_cfg_disable();
      @(posedge clk) begin
         user_o <= 4'h2;
         user_oe <= 4'h8;
         cfg_load <= 1'b1;
         cfg_tap_dis <= 1'b0;
      end
      @(posedge clk) cfg_load <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk(40'(tap_enabled), 40'h1);
      chk(40'(gpio_oe), 40'h0);
      chk(40'(buried_q), 40'h2);
      @(posedge clk) begin
         cfg_load <= 1'b1;
         cfg_tap_dis <= 1'b1;
      end
      @(posedge clk) begin
         cfg_load <= 1'b0;
         cfg_tap_dis <= 1'b0;
      end
      #1;
      chk(40'(tap_enabled), 40'h0);
      @(posedge clk);
      #1;
      chk(40'(gpio_oe), 40'h8);
      chk(40'(gpio_o), 40'h2);
      repeat (3) tap_bit(1'b1, 1'b1);
      tap_bit(1'b0, 1'b1);
      tap_bit(1'b1, 1'b1);
      tap_bit(1'b0, 1'b1);
      tap_bit(1'b0, 1'b1);
      chk(40'(tdo_oe), 40'h0);
      chk(40'(tdo_pad), 40'h0);
      repeat (4) @(posedge clk);
      #1;
      chk(40'(gpio_i), 40'({1'b0, tdi, tms, tck}));
      chk(40'(buried_q), 40'h2);
   endtask : t_cfg_disable

   initial begin
      rst_n = 1'b0;
      cfg_load = 1'b0;
      cfg_tap_dis = 1'b0;
      user_o = 4'h5;
      user_oe = 4'h0;
      err_total = 0;
      checked = 0;
      do_reset();
      t_idcode();
      t_bypass();
      t_ir_idcode();
      t_cfg_disable();
      do_reset();
      t_idcode();
      close_out();
   end
endmodule : tb_top
`default_nettype wire
